//--- rtl/pmic_ctrl_pkg.sv
// package: register map, field positions and shared types of the mask/control bank
package pmic_ctrl_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_GPI_MASK_LOW  = 8'h0C;
  localparam logic [7:0] ADDR_GPI_MASK_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_PWR_DOMAIN    = 8'h0E;
  localparam logic [7:0] ADDR_MISC_PWR      = 8'h0F;
  localparam logic [7:0] ADDR_EVENT_LOW     = 8'h08;
  localparam logic [7:0] ADDR_EVENT_HIGH    = 8'h09;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_MASK     = 8'h00;
  localparam logic [7:0] RST_PWR      = 8'h00;
  localparam logic [7:0] RST_MISC     = 8'h00;
  localparam logic [7:0] RST_EVENT    = 8'h00;
  localparam logic [7:0] RD_UNMAPPED  = 8'h00;

  // ----------------------------------------------------------------
  // power_domain_control fields
  // ----------------------------------------------------------------
  localparam int PWR_PUMP_BIT   = 7;
  localparam int PWR_GUARD2_BIT = 6;
  localparam int PWR_GUARDM_BIT = 5;
  localparam int PWR_GUARDS_BIT = 4;
  localparam int PWR_PARTIAL_BIT = 3;
  localparam int PWR_TGT2_BIT   = 2;
  localparam int PWR_TGTM_BIT   = 1;
  localparam int PWR_TGTS_BIT   = 0;

  // ----------------------------------------------------------------
  // misc_power_control fields (bits 6:5 reserved, read zero)
  // ----------------------------------------------------------------
  localparam int MISC_SOFT_BIT  = 7;
  localparam int MISC_LOCK_BIT  = 4;
  localparam int MISC_RESM_BIT  = 3;
  localparam int MISC_FLASH_BIT = 2;
  localparam int MISC_WDT_BIT   = 1;
  localparam int MISC_CHG_BIT   = 0;
  localparam logic [7:0] MISC_RW_MASK = 8'h9F;

  // reset-event setting at or above this keeps the reset output held
  localparam logic [1:0] RESET_EVENT_HOLD = 2'h3;

  // ----------------------------------------------------------------
  // shared types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic pump_on;
    logic soft_start_on;
    logic key_wake_lock;
    logic reset_on_deep_off_mode_sel;
    logic limited_flash_on;
    logic wdt_in_sleep_sel;
    logic charger_input_sel;
    logic partial_down;
    logic second_domain_target;
    logic main_domain_target;
    logic system_domain_target;
  } ctrl_out_s;

endpackage

//--- rtl/event_flag_bank.sv
// event flag bank: sticky event bits with write-back clear and masked interrupt
`timescale 1ns/1ns
module event_flag_bank
  import pmic_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] event_i,
  input  wire logic [15:0] clear_i,
  input  wire logic [15:0] mask_i,
  output logic      [15:0] flags_o,
  output logic             irq_o
);

  logic [15:0] flags_reg;
  logic [15:0] flags_next;

  // ----------------------------------------------------------------
  // flags: set beats clear so an event in the clear cycle survives
  // ----------------------------------------------------------------
  always_comb
  begin
    flags_next = (flags_reg & ~clear_i) | event_i;
  end

  // flag register
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flags_reg <= {RST_EVENT, RST_EVENT};
    else
      flags_reg <= flags_next;
  end

  assign flags_o = flags_reg;
  // line held while any unmasked flag stays pending
  assign irq_o   = |(flags_reg & ~mask_i);

endmodule

//--- rtl/pmic_ctrl_regs.sv
// mask and power control register bank with event flags and interrupt line
`timescale 1ns/1ns
module pmic_ctrl_regs
  import pmic_ctrl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // event sources, one-cycle pulses
  input  wire logic [15:0] event_i,
  // domain enable pins, level
  input  wire logic        second_domain_pin_i,
  input  wire logic        main_domain_pin_i,
  input  wire logic        system_domain_pin_i,
  // sequencer status
  input  wire logic        power_up_seq_i,
  input  wire logic        power_down_start_i,
  input  wire logic        deep_off_exit_i,
  input  wire logic [1:0]  reset_event_i,
  // outputs
  output ctrl_out_s        ctrl_o,
  output logic             full_down_req_o,
  output logic             partial_down_req_o,
  output logic             reset_output_n_o,
  output logic             interrupt_line_n_o
);

  reg_req_s    req;
  logic [7:0]  mask_low_reg;
  logic [7:0]  mask_low_next;
  logic [7:0]  mask_high_reg;
  logic [7:0]  mask_high_next;
  logic [7:0]  pwr_reg;
  logic [7:0]  pwr_next;
  logic [7:0]  misc_reg;
  logic [7:0]  misc_next;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic [2:0]  pins_reg;
  logic [2:0]  pins_next;
  logic        rst_hold_reg;
  logic        rst_hold_next;
  logic        sys_fall_reg;
  logic        sys_fall_next;
  logic [15:0] flags;
  logic [15:0] clear;
  logic        irq;
  logic [2:0]  pins_now;
  logic [2:0]  guard;
  logic [2:0]  target_next;
  logic        wr_event_low;
  logic        wr_event_high;
  logic        wr_mask_low;
  logic        wr_mask_high;
  logic        wr_pwr;
  logic        wr_misc;

  // bundle the port pins into one request
  assign req = '{wr: wr_i, rd: rd_i, addr: addr_i, wdata: wdata_i};

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  // one select per register; an unmapped address selects nothing, so
  // a stray write is dropped without touching any state
  assign wr_event_low  = req.wr && (req.addr == ADDR_EVENT_LOW);
  assign wr_event_high = req.wr && (req.addr == ADDR_EVENT_HIGH);
  assign wr_mask_low   = req.wr && (req.addr == ADDR_GPI_MASK_LOW);
  assign wr_mask_high  = req.wr && (req.addr == ADDR_GPI_MASK_HIGH);
  assign wr_pwr        = req.wr && (req.addr == ADDR_PWR_DOMAIN);
  assign wr_misc       = req.wr && (req.addr == ADDR_MISC_PWR);

  // ----------------------------------------------------------------
  // event flags and interrupt
  // ----------------------------------------------------------------
  // write-back clear: each written one clears the matching flag, unless its event fires in the same cycle
  always_comb
  begin
    clear = 16'h0000;
    if (wr_event_low)
      clear[7:0] = req.wdata;
    if (wr_event_high)
      clear[15:8] = req.wdata;
  end

  // sticky flags live in their own bank; masks act only on the line
  event_flag_bank u_flags (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .event_i (event_i),
    .clear_i (clear),
    .mask_i  ({mask_high_reg, mask_low_reg}),
    .flags_o (flags),
    .irq_o   (irq)
  );

  // active low line, low while any unmasked flag pends
  assign interrupt_line_n_o = ~irq;

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  // plain read/write storage
  always_comb
  begin
    mask_low_next  = mask_low_reg;
    mask_high_next = mask_high_reg;
    if (wr_mask_low)
      mask_low_next = req.wdata;
    if (wr_mask_high)
      mask_high_next = req.wdata;
  end

  // mask registers; a new mask acts on the line one cycle after the
  // write, pending flags are not touched by it
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mask_low_reg  <= RST_MASK;
      mask_high_reg <= RST_MASK;
    end
    else
    begin
      mask_low_reg  <= mask_low_next;
      mask_high_reg <= mask_high_next;
    end
  end

  // ----------------------------------------------------------------
  // power domain control
  // ----------------------------------------------------------------
  // pin edges also move targets; a write in the same cycle as a pin
  // edge loses to the pin, since the pin reflects the newest request
  assign pins_now = {second_domain_pin_i, main_domain_pin_i, system_domain_pin_i};
  assign guard    = {pwr_reg[PWR_GUARD2_BIT], pwr_reg[PWR_GUARDM_BIT],
                     pwr_reg[PWR_GUARDS_BIT]};

  // one target per domain; a guard counts only once it is stored, so
  // a write that sets a guard still moves its own target
  for (genvar g = 0; g < 3; g++)
  begin : g_target
    assign target_next[g] = (pins_now[g] != pins_reg[g]) ? pins_now[g] :
                            (wr_pwr && !guard[g]) ? req.wdata[PWR_TGTS_BIT + g] :
                            pwr_reg[PWR_TGTS_BIT + g];
  end

  // bits 7:3 follow any write, the targets come from the loop above
  always_comb
  begin
    pwr_next = pwr_reg;
    if (wr_pwr)
      pwr_next[7:3] = req.wdata[7:3];
    pwr_next[PWR_TGT2_BIT:PWR_TGTS_BIT] = target_next;
    pins_next = pins_now;
  end

  // power register and pin history
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pwr_reg  <= RST_PWR;
      pins_reg <= 3'h0;
    end
    else
    begin
      pwr_reg  <= pwr_next;
      pins_reg <= pins_next;
    end
  end

  // ----------------------------------------------------------------
  // system power down request
  // ----------------------------------------------------------------
  // one-cycle request when the system target falls, depth from bit 3
  always_comb
  begin
    sys_fall_next = pwr_reg[PWR_TGTS_BIT] & ~pwr_next[PWR_TGTS_BIT];
  end

  // fall marker, registered beside the target itself
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sys_fall_reg <= 1'b0;
    else
      sys_fall_reg <= sys_fall_next;
  end

  // depth bit read as stored after the fall, so a write that clears the
  // target and flips the depth at once takes the new depth
  assign full_down_req_o    = sys_fall_reg & ~pwr_reg[PWR_PARTIAL_BIT];
  assign partial_down_req_o = sys_fall_reg & pwr_reg[PWR_PARTIAL_BIT];

  // ----------------------------------------------------------------
  // misc power control and reset output
  // ----------------------------------------------------------------
  // reserved bits are dropped on the way in so they always read zero;
  // soft-start timing lives in the buck, only its enable is kept here
  always_comb
  begin
    misc_next     = misc_reg;
    rst_hold_next = rst_hold_reg;
    if (wr_misc)
      misc_next = req.wdata & MISC_RW_MASK;
    // the lock bit self-clears on power-up, over any host write
    if (power_up_seq_i)
      misc_next[MISC_LOCK_BIT] = 1'b0;
    // reset held from start of power down until exit, if allowed
    if (power_down_start_i && misc_reg[MISC_RESM_BIT])
      rst_hold_next = 1'b1;
    else if (deep_off_exit_i && reset_event_i < RESET_EVENT_HOLD)
      rst_hold_next = 1'b0;
  end

  // misc register and reset hold flag
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      misc_reg     <= RST_MISC;
      rst_hold_reg <= 1'b0;
    end
    else
    begin
      misc_reg     <= misc_next;
      rst_hold_reg <= rst_hold_next;
    end
  end

  // assert before the sequence: combinational with the start pulse
  assign reset_output_n_o = ~(rst_hold_reg |
                              (power_down_start_i & misc_reg[MISC_RESM_BIT]));

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // register fields straight out, no logic between flop and pin
  assign ctrl_o.pump_on                = pwr_reg[PWR_PUMP_BIT];
  assign ctrl_o.soft_start_on          = misc_reg[MISC_SOFT_BIT];
  assign ctrl_o.key_wake_lock          = misc_reg[MISC_LOCK_BIT];
  assign ctrl_o.reset_on_deep_off_mode_sel = misc_reg[MISC_RESM_BIT];
  assign ctrl_o.limited_flash_on       = misc_reg[MISC_FLASH_BIT];
  assign ctrl_o.wdt_in_sleep_sel       = misc_reg[MISC_WDT_BIT];
  assign ctrl_o.charger_input_sel      = misc_reg[MISC_CHG_BIT];
  assign ctrl_o.partial_down           = pwr_reg[PWR_PARTIAL_BIT];
  assign ctrl_o.second_domain_target   = pwr_reg[PWR_TGT2_BIT];
  assign ctrl_o.main_domain_target     = pwr_reg[PWR_TGTM_BIT];
  assign ctrl_o.system_domain_target   = pwr_reg[PWR_TGTS_BIT];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // data stand in the cycle after the strobe only
  always_comb
  begin
    rdata_next = RD_UNMAPPED;
    if (req.rd)
    begin
      unique case (req.addr)
        ADDR_EVENT_LOW:     rdata_next = flags[7:0];
        ADDR_EVENT_HIGH:    rdata_next = flags[15:8];
        ADDR_GPI_MASK_LOW:  rdata_next = mask_low_reg;
        ADDR_GPI_MASK_HIGH: rdata_next = mask_high_reg;
        ADDR_PWR_DOMAIN:    rdata_next = pwr_reg;
        ADDR_MISC_PWR:      rdata_next = misc_reg;
        default:            rdata_next = RD_UNMAPPED;
      endcase
    end
  end

  // read data register; zero between reads so a stale value never
  // looks like an answer to a later strobe
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      rdata_reg <= RD_UNMAPPED;
    else
      rdata_reg <= rdata_next;
  end

  // data output straight from the flop
  assign rdata_o = rdata_reg;

endmodule

//--- verif/pmic_ctrl_regs_monitor.sv
// checker: port-level assertions of the mask and power control bank
`timescale 1ns/1ns
module pmic_ctrl_regs_monitor
  import pmic_ctrl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [15:0] event_i,
  input wire logic        power_up_seq_i,
  input wire logic        power_down_start_i,
  input wire logic        deep_off_exit_i,
  input wire logic [1:0]  reset_event_i,
  input wire ctrl_out_s   ctrl_o,
  input wire logic        full_down_req_o,
  input wire logic        partial_down_req_o,
  input wire logic        reset_output_n_o,
  input wire logic        interrupt_line_n_o
);
  // ------------------------------------------------
  // assertions, one clock domain
  // ------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  chk_pump_follow: assert property (
    wr_i && addr_i == ADDR_PWR_DOMAIN |=> ctrl_o.pump_on == $past(wdata_i[PWR_PUMP_BIT]))
    else $error("pump enable missed the write");
  chk_down_select: assert property (
    $fell(ctrl_o.system_domain_target) && $stable(ctrl_o.partial_down)
    |-> full_down_req_o != ctrl_o.partial_down && partial_down_req_o == ctrl_o.partial_down)
    else $error("wrong power-down request");
  chk_req_cause: assert property (
    full_down_req_o || partial_down_req_o |-> $fell(ctrl_o.system_domain_target))
    else $error("power-down request without target fall");
  chk_irq_cause: assert property (
    $fell(interrupt_line_n_o) |-> $past(event_i) != 16'h0000 || $past(wr_i))
    else $error("interrupt without event or mask change");
  chk_irq_hold: assert property (
    !interrupt_line_n_o && !wr_i |=> !interrupt_line_n_o)
    else $error("interrupt released without a clear");
  chk_pwr_read: assert property (
    rd_i && addr_i == ADDR_PWR_DOMAIN |=> rdata_o[7] == $past(ctrl_o.pump_on)
    && rdata_o[3] == $past(ctrl_o.partial_down))
    else $error("power control read mismatch");
  chk_misc_read: assert property (
    rd_i && addr_i == ADDR_MISC_PWR |=> rdata_o[6:5] == 2'h0
    && rdata_o[7] == $past(ctrl_o.soft_start_on) && rdata_o[0] == $past(ctrl_o.charger_input_sel))
    else $error("misc control read mismatch");
  chk_reset_assert: assert property (
    power_down_start_i && ctrl_o.reset_on_deep_off_mode_sel |-> !reset_output_n_o)
    else $error("reset output not asserted");
  chk_reset_release: assert property (
    !reset_output_n_o && deep_off_exit_i && reset_event_i < RESET_EVENT_HOLD
    && !power_down_start_i |=> reset_output_n_o)
    else $error("reset output not released");
  chk_lock_clear: assert property (
    power_up_seq_i && !wr_i |=> !ctrl_o.key_wake_lock)
    else $error("key lock not cleared on power-up");
endmodule

bind pmic_ctrl_regs pmic_ctrl_regs_monitor u_pmic_ctrl_regs_monitor (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i), .power_up_seq_i(power_up_seq_i),
  .power_down_start_i(power_down_start_i), .deep_off_exit_i(deep_off_exit_i),
  .reset_event_i(reset_event_i), .ctrl_o(ctrl_o), .full_down_req_o(full_down_req_o),
  .partial_down_req_o(partial_down_req_o), .reset_output_n_o(reset_output_n_o),
  .interrupt_line_n_o(interrupt_line_n_o));

//--- verif/host_bfm.sv
// partner: host processor model driving the register port
`timescale 1ns/1ns
module host_bfm
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic      [7:0] addr_o  = 8'h00,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            wr_o    = 1'h0,
  output logic            rd_o    = 1'h0
);
  // one-cycle write; data flipped after so stale data never looks valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'h1;
    @(posedge clk_i);
    wr_o    <= 1'h0;
    wdata_o <= ~d;
    #1;
  endtask
  // one-cycle read; data taken while it stands in the next cycle
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'h1;
    @(posedge clk_i);
    rd_o <= 1'h0;
    #1;
    d = rdata_i;
  endtask
endmodule

//--- verif/test_pmic_ctrl_regs.sv
// testbench: self-checking run of the mask and power control bank
`timescale 1ns/1ns
module test_pmic_ctrl_regs
  import pmic_ctrl_pkg::*;
;
  logic        clk_i   = 1'h0;
  logic        rst_n_i = 1'h0;
  logic [7:0]  addr_i;
  logic [7:0]  wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [7:0]  rdata_o;
  logic [15:0] event_i = 16'h0000;
  logic [2:0]  pins    = 3'h0;
  logic        pup     = 1'h0;
  logic        pds     = 1'h0;
  logic        dox     = 1'h0;
  logic [1:0]  rev     = 2'h0;
  ctrl_out_s   ctrl_o;
  logic        full_req;
  logic        part_req;
  logic        rst_out_n;
  logic        irq_n;
  int          num_errors = 0;
  int          compares   = 0;
  logic [31:0] seed       = 32'h80EB;
  logic [7:0]  d;

  always #5 clk_i = ~clk_i;

  host_bfm u_host_bfm (.clk_i(clk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i));
  pmic_ctrl_regs u_pmic_ctrl_regs (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .event_i(event_i),
    .second_domain_pin_i(pins[2]), .main_domain_pin_i(pins[1]), .system_domain_pin_i(pins[0]),
    .power_up_seq_i(pup), .power_down_start_i(pds), .deep_off_exit_i(dox),
    .reset_event_i(rev), .ctrl_o(ctrl_o), .full_down_req_o(full_req),
    .partial_down_req_o(part_req), .reset_output_n_o(rst_out_n), .interrupt_line_n_o(irq_n));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reserved misc bits never store
  function automatic logic [7:0] exp_misc(input logic [7:0] v);
    return v & MISC_RW_MASK;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_host_bfm.read(a, d);
    check(d, exp);
  endtask
  task automatic ev_pulse(input logic [15:0] v);
    @(posedge clk_i);
    event_i <= v;
    @(posedge clk_i);
    event_i <= 16'h0000;
    #1;
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    rd_chk(ADDR_GPI_MASK_LOW, RST_MASK);
    rd_chk(ADDR_GPI_MASK_HIGH, RST_MASK);
    rd_chk(ADDR_PWR_DOMAIN, RST_PWR);
    rd_chk(ADDR_MISC_PWR, RST_MISC);
    rd_chk(8'h20, RD_UNMAPPED);
    $display("test reset values done");
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      u_host_bfm.write(ADDR_GPI_MASK_LOW, seed[7:0]);
      u_host_bfm.write(ADDR_GPI_MASK_HIGH, seed[15:8]);
      u_host_bfm.write(ADDR_MISC_PWR, seed[23:16]);
      check({ctrl_o[9], 2'h0, ctrl_o[8:4]}, exp_misc(seed[23:16]));
      rd_chk(ADDR_GPI_MASK_LOW, seed[7:0]);
      rd_chk(ADDR_GPI_MASK_HIGH, seed[15:8]);
      rd_chk(ADDR_MISC_PWR, exp_misc(seed[23:16]));
    end
    $display("test random fields done");
    u_host_bfm.write(ADDR_MISC_PWR, 8'h00);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h87);
    check({7'h00, ctrl_o.pump_on}, 8'h01);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h70);
    check({6'h00, full_req, part_req}, 8'h02);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h77);
    rd_chk(ADDR_PWR_DOMAIN, 8'h70);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h0F);
    rd_chk(ADDR_PWR_DOMAIN, 8'h08);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h0F);
    u_host_bfm.write(ADDR_PWR_DOMAIN, 8'h08);
    check({6'h00, full_req, part_req}, 8'h01);
    @(posedge clk_i);
    pins <= 3'h7;
    repeat (3) @(posedge clk_i);
    #1 check({5'h00, ctrl_o[2:0]}, 8'h07);
    rd_chk(ADDR_PWR_DOMAIN, 8'h0F);
    // releasing all three domain pins at once must start the partial power-down request
    @(posedge clk_i);
    pins <= 3'h0;
    @(posedge clk_i);
    #1 check({6'h00, full_req, part_req}, 8'h01);
    repeat (2) @(posedge clk_i);
    rd_chk(ADDR_PWR_DOMAIN, 8'h08);
    $display("test power domains done");
    u_host_bfm.write(ADDR_GPI_MASK_LOW, 8'h00);
    u_host_bfm.write(ADDR_GPI_MASK_HIGH, 8'h00);
    ev_pulse(16'h0201);
    check({7'h00, irq_n}, 8'h00);
    u_host_bfm.write(ADDR_EVENT_LOW, 8'h01);
    check({7'h00, irq_n}, 8'h00);
    u_host_bfm.write(ADDR_EVENT_HIGH, 8'h02);
    check({7'h00, irq_n}, 8'h01);
    u_host_bfm.write(ADDR_GPI_MASK_HIGH, 8'h40);
    ev_pulse(16'h4000);
    check({7'h00, irq_n}, 8'h01);
    rd_chk(ADDR_EVENT_HIGH, 8'h40);
    u_host_bfm.write(ADDR_GPI_MASK_HIGH, 8'h00);
    check({7'h00, irq_n}, 8'h00);
    u_host_bfm.write(ADDR_EVENT_HIGH, 8'h40);
    check({7'h00, irq_n}, 8'h01);
    $display("test interrupt done");
    u_host_bfm.write(ADDR_MISC_PWR, 8'h18);
    @(posedge clk_i);
    pds <= 1'h1;
    #1 check({7'h00, rst_out_n}, 8'h00);
    @(posedge clk_i);
    pds <= 1'h0;
    // held reset setting first, then a releasing one
    for (int j = 0; j < 2; j++)
    begin
      rev <= j ? 2'h0 : RESET_EVENT_HOLD;
      dox <= 1'h1;
      @(posedge clk_i);
      dox <= 1'h0;
      #1 check({7'h00, rst_out_n}, j[7:0]);
      @(posedge clk_i);
    end
    pup <= 1'h1;
    @(posedge clk_i);
    pup <= 1'h0;
    #1 check({7'h00, ctrl_o.key_wake_lock}, 8'h00);
    rd_chk(ADDR_MISC_PWR, 8'h08);
    $display("test reset output and key lock done");
    complete_run();
  end

  // hang guard, far beyond the under two hundred cycles the run needs
  initial
  begin
    #100000;
    num_errors++;
    complete_run();
  end
endmodule
